//--- core/wrap_fifo.sv
/*
  Wrapping FIFO with dynamic threshold flags: a memory sized to the physical
  block, a 4-word write staging buffer, optional wrap on write and on read,
  and almost-full/almost-empty thresholds reloadable at run time.
  Assumes a single clock and user logic that uses one data width both sides.
*/
`include "wfifo_consts.svh"

module wrap_fifo #(
  parameter int DATA_W     = `WFIFO_DATA_W,
  parameter int ADDR_W     = `WFIFO_ADDR_W,
  parameter int STAGE_DEPTH = `WFIFO_STAGE_DEPTH
) (
  // Clock and reset.
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // Mode straps.
  input  wire logic              wrap_wr_i,
  input  wire logic              wrap_rd_i,
  input  wire logic              dyn_mode_i,
  // Threshold reloads.
  input  wire logic              user_load_i,
  input  wire logic [ADDR_W:0]   user_afull_i,
  input  wire logic [ADDR_W:0]   user_aempty_i,
  input  wire logic              test_port_user_access_load_i,
  input  wire logic [ADDR_W:0]   test_port_user_access_afull_i,
  input  wire logic [ADDR_W:0]   test_port_user_access_aempty_i,
  // Write side.
  input  wire logic              wr_valid_i,
  output logic                   wr_ready_o,
  input  wire logic [DATA_W-1:0] wr_data_i,
  // Read side.
  input  wire logic              rd_req_i,
  output logic                   rd_valid_o,
  output logic [DATA_W-1:0]      rd_data_o,
  // Flags.
  output logic                   full_o,
  output logic                   empty_o,
  output logic                   afull_o,
  output logic                   aempty_o,
  output logic [ADDR_W:0]        level_o,
  output wfifo_pkg::load_src_e   last_load_o
);
  import wfifo_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W:0] FULL_LVL = (ADDR_W+1)'(DEPTH);
  localparam logic [ADDR_W:0] AFULL_FIX = (ADDR_W+1)'(`WFIFO_AFULL_RST);
  localparam logic [ADDR_W:0] AEMPTY_FIX = (ADDR_W+1)'(`WFIFO_AEMPTY_RST);

  // ----------------------------------------------------------------------
  // Storage and staging
  // ----------------------------------------------------------------------
  stage_if #(.W(DATA_W)) stg ();

  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wp_reg;
  logic [ADDR_W-1:0] rp_reg;
  logic [ADDR_W:0]   cnt_reg;
  logic [ADDR_W:0]   afull_thr_reg;
  logic [ADDR_W:0]   aempty_thr_reg;
  logic [ADDR_W:0]   afull_use;
  logic [ADDR_W:0]   aempty_use;
  logic              is_full;
  logic              is_empty;
  logic              do_wr;
  logic              do_rd;

  stage_fifo #(
    .W     (DATA_W),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .in_valid_i (wr_valid_i),
    .in_ready_o (wr_ready_o),
    .in_data_i  (wr_data_i),
    .out        (stg)
  );

  // Full counts against the whole physical array, never a smaller request.
  assign is_full  = (cnt_reg == FULL_LVL);
  assign is_empty = (cnt_reg == '0);

  // A full FIFO back-pressures the stage unless wrap-on-write is on.
  assign stg.ready = !is_full || wrap_wr_i;
  assign do_wr     = stg.valid && stg.ready;
  // Empty reads are dropped unless wrap-on-read replays old words.
  assign do_rd     = rd_req_i && (!is_empty || wrap_rd_i);

  // Memory write; overwrites the oldest word when wrapping past full.
  always_ff @(posedge core_clk_i)
  begin
    if (do_wr)
      mem[wp_reg] <= stg.data;
  end

  // Pointers roll over naturally at the power-of-two depth.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      if (do_wr)
        wp_reg <= wp_reg + 1'b1;
      if (do_rd)
        rp_reg <= rp_reg + 1'b1;
    end
  end

  // Occupancy saturates at full and at empty so wrapping keeps it sane.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_reg <= '0;
    else if (do_wr && !do_rd && !is_full)
      cnt_reg <= cnt_reg + 1'b1;
    else if (do_rd && !do_wr && !is_empty)
      cnt_reg <= cnt_reg - 1'b1;
  end

  // Read data and its valid strobe come from flip-flops.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end
    else
    begin
      rd_valid_o <= do_rd;
      if (do_rd)
        rd_data_o <= mem[rp_reg];
    end
  end

  // ----------------------------------------------------------------------
  // Dynamic thresholds
  // ----------------------------------------------------------------------
  // User logic wins a same-cycle clash: it is the faster path and the test
  // port load can simply be repeated.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      afull_thr_reg  <= AFULL_FIX;
      aempty_thr_reg <= AEMPTY_FIX;
      last_load_o    <= LOAD_NONE;
    end
    else if (user_load_i)
    begin
      afull_thr_reg  <= user_afull_i;
      aempty_thr_reg <= user_aempty_i;
      last_load_o    <= LOAD_USER;
    end
    else if (test_port_user_access_load_i)
    begin
      afull_thr_reg  <= test_port_user_access_afull_i;
      aempty_thr_reg <= test_port_user_access_aempty_i;
      last_load_o    <= LOAD_TEST;
    end
  end

  assign afull_use  = dyn_mode_i ? afull_thr_reg : AFULL_FIX;
  assign aempty_use = dyn_mode_i ? aempty_thr_reg : AEMPTY_FIX;

  // Flags are registered from the current occupancy.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      full_o   <= 1'b0;
      empty_o  <= 1'b1;
      afull_o  <= 1'b0;
      aempty_o <= 1'b1;
      level_o  <= '0;
    end
    else
    begin
      full_o   <= is_full;
      empty_o  <= is_empty;
      afull_o  <= (cnt_reg >= afull_use);
      aempty_o <= (cnt_reg <= aempty_use);
      level_o  <= cnt_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_load_user;
    user_load_i ##1 1'b1;
  endsequence

  property p_wrap_wr;
    @(posedge core_clk_i) disable iff (rst_i)
      (is_full && wrap_wr_i && stg.valid) |=> (wp_reg == $past(wp_reg) + 1'b1);
  endproperty
  a_wrap_wr: assert property (p_wrap_wr) else $error("wrap write did not advance");

  property p_wrap_rd;
    @(posedge core_clk_i) disable iff (rst_i)
      (is_empty && wrap_rd_i && rd_req_i) |=> rd_valid_o && (rp_reg == $past(rp_reg) + 1'b1);
  endproperty
  a_wrap_rd: assert property (p_wrap_rd) else $error("wrap read did not replay");

  property p_full_depth;
    @(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> (full_o == ($past(cnt_reg) == FULL_LVL));
  endproperty
  a_full_depth: assert property (p_full_depth) else $error("full not at physical depth");

  property p_dyn_afull;
    @(posedge core_clk_i) disable iff (rst_i)
      dyn_mode_i |=> (afull_o == ($past(cnt_reg) >= $past(afull_thr_reg)));
  endproperty
  a_dyn_afull: assert property (p_dyn_afull) else $error("almost full ignores register");

  property p_reload;
    @(posedge core_clk_i) disable iff (rst_i)
      s_load_user |-> (afull_thr_reg == $past(user_afull_i)) && (last_load_o == LOAD_USER);
  endproperty
  a_reload: assert property (p_reload) else $error("threshold reload lost");

  property p_no_ovf;
    @(posedge core_clk_i) disable iff (rst_i)
      (is_full && !wrap_wr_i) |=> (wp_reg == $past(wp_reg));
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("write taken while full");

  property p_no_udf;
    @(posedge core_clk_i) disable iff (rst_i)
      (is_empty && !wrap_rd_i && !do_wr) |=> !rd_valid_o && (rp_reg == $past(rp_reg));
  endproperty
  a_no_udf: assert property (p_no_udf) else $error("read taken while empty");
endmodule

//--- core/wfifo_consts.svh
/*
  Constants for the wrapping FIFO with dynamic threshold flags.
  Assumes inclusion by bare name from the core files; holds definitions only.
*/
// Contract
// - With wrap-on-write selected, the write pointer rolls over after the last location and writes keep being stored.
// - With wrap-on-read selected, the read pointer rolls over and previously read words are returned again.
// - The full flag follows the physical memory depth, not a smaller requested depth.
// - In dynamic mode the threshold flags compare against register values, not build-time constants.
// - The threshold registers can be reloaded at run time from user logic or the test-port user access path.
`ifndef WFIFO_CONSTS_SVH
`define WFIFO_CONSTS_SVH

// ----------------------------------------------------------------------
// Geometry and reset values
// ----------------------------------------------------------------------
`define WFIFO_DATA_W      8
`define WFIFO_ADDR_W      8
`define WFIFO_STAGE_DEPTH 4
`define WFIFO_MAX_BLOCKS  64
`define WFIFO_AFULL_RST   8'he0
`define WFIFO_AEMPTY_RST  8'h20

`endif

//--- core/wfifo_pkg.sv
/*
  Types shared by the wrapping FIFO files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package wfifo_pkg;
  // Origin of a threshold reload.
  typedef enum logic [1:0]
  {
    LOAD_NONE = 2'b00,
    LOAD_USER = 2'b01,
    LOAD_TEST = 2'b10
  } load_src_e;
endpackage

//--- core/stage_if.sv
/*
  Valid/ready carrier between the write staging FIFO and the storage core.
  Assumes one clock shared by both ends.
*/
interface stage_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- core/stage_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
module stage_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // Fill side.
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side.
  stage_if.src              out
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  // Honest flags: ready only while a slot is free, valid only while one is held.
  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out.valid  = (cnt_reg != '0);
  assign out.data   = mem[rp_reg];
  assign push       = in_valid_i && in_ready_o;
  assign pop        = out.valid && out.ready;

  // Storage array; no reset so it maps onto plain memory.
  always_ff @(posedge core_clk_i)
  begin
    if (push)
      mem[wp_reg] <= in_data_i;
  end

  // Pointers and occupancy.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      if (pop)
        rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- dv/user_side.sv
/*
  Far-side user logic: offers write words and raises read requests.
  Assumes inputs change at the rising edge of the FIFO clock; outputs are driven and inputs sampled at the falling edge.
*/
module user_side (
  // Clock.
  input  wire logic       core_clk_i,
  // Write side.
  output logic            wr_valid_o,
  input  wire logic       wr_ready_i,
  output logic [7:0]      wr_data_o,
  // Read side.
  output logic            rd_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BLOCKS = 1; // One block, far under the cascade limit.

  // Idle lines start low; data has no meaning yet.
  initial
  begin
    wr_valid_o = 1'b0;
    wr_data_o  = 8'h5a;
    rd_req_o   = 1'b0;
  end

  // Offer one word, same width as reads; a refused word is withdrawn after 9 cycles.
  task automatic push(input logic [7:0] d, input int gap, output bit ok);
    int w;
    w = 0;
    @(negedge core_clk_i);
    if (gap > 0)
    begin
      wr_valid_o = 1'b0;
      wr_data_o  = ~wr_data_o;
      repeat (gap) @(negedge core_clk_i);
    end
    wr_valid_o = 1'b1;
    wr_data_o  = d;
    while (wr_ready_i !== 1'b1 && w < 8)
    begin
      @(negedge core_clk_i);
      w++;
    end
    ok = (wr_ready_i === 1'b1);
    if (ok)
      @(posedge core_clk_i);
    else
      idle();
  endtask

  // Released data shows the inverse so a stale value never passes as fresh.
  task automatic idle();
    @(negedge core_clk_i);
    wr_valid_o = 1'b0;
    wr_data_o  = ~wr_data_o;
  endtask

  task automatic set_rd(input bit on);
    rd_req_o = on;
  endtask
endmodule

//--- dv/tb.sv
/*
  Self-checking bench for the wrapping FIFO against a queue and array model.
  Assumes the design defaults: 8-bit data, 256-word memory, 4-word stage.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wfifo_pkg::*;
  logic       core_clk_i = 0, rst_i = 1, wrap_wr, wrap_rd, dyn, uld, tld;
  logic [8:0] uaf, uae, taf, tae, lvl;
  logic       wv, wrdy, rq, rv, fl, em, af, ae;
  logic [7:0] wd, rd;
  load_src_e  ll;
  int         bad_count = 0, total_checks = 0, cnt = 0, wp = 0, rp = 0;
  logic [7:0] mem [256];
  logic [7:0] stq [$];
  bit [31:0]  seed = 32'h6305;
  bit         ok;

  // Free-running core clock, 50 ns period.
  always #25 core_clk_i = ~core_clk_i;

  wrap_fifo u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .wrap_wr_i(wrap_wr),
    .wrap_rd_i(wrap_rd), .dyn_mode_i(dyn), .user_load_i(uld), .user_afull_i(uaf),
    .user_aempty_i(uae), .test_port_user_access_load_i(tld),
    .test_port_user_access_afull_i(taf), .test_port_user_access_aempty_i(tae),
    .wr_valid_i(wv), .wr_ready_o(wrdy), .wr_data_i(wd), .rd_req_i(rq), .rd_valid_o(rv),
    .rd_data_o(rd), .full_o(fl), .empty_o(em), .afull_o(af), .aempty_o(ae),
    .level_o(lvl), .last_load_o(ll));
  user_side u_usr (.core_clk_i(core_clk_i), .wr_valid_o(wv), .wr_ready_i(wrdy),
    .wr_data_o(wd), .rd_req_o(rq));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Staged words enter the model memory when room or overwrite is allowed.
  function automatic void drain();
    while (stq.size() > 0 && (cnt < 256 || wrap_wr))
    begin
      mem[wp] = stq.pop_front();
      wp = (wp + 1) % 256;
      if (cnt < 256) cnt++;
    end
  endfunction

  task automatic wr(input int n, input bit slow);
    logic [7:0] d;
    for (int i = 0; i < n; i++)
    begin
      d = rnd();
      u_usr.push(d, slow ? int'(d % 3) : 0, ok);
      if (ok) stq.push_back(d);
      drain();
    end
    u_usr.idle();
    repeat (3) @(negedge core_clk_i);
  endtask

  // Back-to-back requests; each answer is checked one cycle later.
  task automatic pop(input int n);
    logic [8:0] ev, ed;
    for (int i = 0; i <= n; i++)
    begin
      @(negedge core_clk_i);
      if (i > 0) chk("rd_valid", ev, {8'h0, rv});
      if (i > 0 && ev[0]) chk("rd_data", ed, {1'b0, rd});
      u_usr.set_rd(i < n);
      ev = 9'(cnt > 0 || wrap_rd);
      ed = {1'b0, mem[rp]};
      if (i < n && ev[0])
      begin
        rp = (rp + 1) % 256;
        if (cnt > 0) cnt--;
        drain();
      end
    end
    repeat (2) @(negedge core_clk_i);
  endtask

  task automatic fc(input logic [8:0] l, input logic [3:0] f);
    chk("level", l, lvl);
    chk("full empty afull aempty", {5'h0, f}, {5'h0, fl, em, af, ae});
  endtask

  task automatic load(input bit u, t, input logic [8:0] a, b, c, d);
    @(negedge core_clk_i);
    {uld, tld, uaf, uae, taf, tae} = {u, t, a, b, c, d};
    @(negedge core_clk_i);
    {uld, tld} = 2'b00;
    repeat (2) @(negedge core_clk_i);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the sequence needs under 1000 cycles.
  initial
  begin
    #1000000;
    bad_count++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    {wrap_wr, wrap_rd, dyn, uld, tld, uaf, uae, taf, tae} = '0;
    repeat (8) @(negedge core_clk_i);
    fc(9'h0, 4'b0101);
    chk("wr_ready", 9'h1, {8'h0, wrdy});
    chk("last_load", 9'(LOAD_NONE), {7'h0, ll});
    rst_i = 1'b0;
    wr(20, 1);
    pop(20);
    wr(261, 0);
    fc(9'h100, 4'b1010);
    chk("wr_ready", 9'h0, {8'h0, wrdy});
    pop(262);
    fc(9'h0, 4'b0101);
    wrap_rd = 1'b1;
    wr(3, 0);
    pop(7);
    wrap_rd = 1'b0;
    dyn = 1'b1;
    wr(10, 0);
    fc(9'h00a, 4'b0001);
    load(1, 0, 9'h005, 9'h002, 9'h0, 9'h0);
    fc(9'h00a, 4'b0010);
    chk("last_load", 9'(LOAD_USER), {7'h0, ll});
    load(0, 1, 9'h0, 9'h0, 9'h100, 9'h00c);
    fc(9'h00a, 4'b0001);
    chk("last_load", 9'(LOAD_TEST), {7'h0, ll});
    load(1, 1, 9'h003, 9'h001, 9'h100, 9'h00c);
    fc(9'h00a, 4'b0010);
    chk("last_load", 9'(LOAD_USER), {7'h0, ll});
    dyn = 1'b0;
    repeat (2) @(negedge core_clk_i);
    fc(9'h00a, 4'b0001);
    wrap_wr = 1'b1;
    wr(250, 0);
    fc(9'h100, 4'b1010);
    pop(5);
    close_out();
  end
endmodule
